// ---- rtl/legacy_audio_regs.vh ----
// register offsets, field positions and constants of the legacy audio bank
`ifndef LEGACY_AUDIO_REGS_VH
`define LEGACY_AUDIO_REGS_VH
`define OFS_FM_LOW_INDEX 4'h0
`define OFS_FM_LOW_DATA 4'h1
`define OFS_FM_HIGH_INDEX 4'h2
`define OFS_FM_HIGH_DATA 4'h3
`define OFS_MIXER_INDEX 4'h4
`define OFS_MIXER_VALUE 4'h5
`define OFS_RESET_FLAGS 4'h6
`define OFS_POWER_CONTROL 4'h7
`define OFS_PROC_READ_DATA 4'ha
`define OFS_HANDSHAKE 4'hc
`define OFS_READ_BUF_STATE 4'he
`define OFS_FIFO_PIO 4'hf
`define BIT_SOFT_CORE_HOLD 0
`define BIT_FIFO_HOLD 1
`define BIT_MIDI_PENDING 2
`define BIT_SERIAL_ACT 4
`define BIT_GEN_ACT 5
`define BIT_MIX_ACT 6
`define BIT_SUSPEND_REQ 7
`define BIT_GENERAL_INPUT 6
`define BIT_FM_HOLD 5
`define BIT_BUSY 7
`define BIT_AVAIL 6
`define BIT_FIFO_FULL 5
`define BIT_FIFO_EMPTY 4
`define BIT_FIFO_HALF 3
`define BIT_PROC_IRQ 2
`define BIT_HALF_IRQ 1
`define BIT_OVF_IRQ 0
`define BIT_READ_SIDE_AVAIL_FLAG 7
`define SER_ENABLE_BIT 7
`define SER_RESET_BIT 5
`define SER_ACTIVE_BIT 4
`define MIXER_SERIAL_REG 7'h48
`define RESET_BYTE 8'h00
`define FIFO_DEPTH 256
`define FIFO_AW 8
`define FIFO_HALF_LEVEL 9'h080
`define SCLK_WINDOW 8'hff
`endif

// ---- rtl/audio_fifo.v ----
// byte fifo with valid/ready on both sides, register read data
module audio_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire [AW:0] depth_w;
  assign depth_w = DEPTH[AW:0];
  assign in_ready = (count_ff != depth_w);
  assign push = in_valid && in_ready;
  // output register counts as one stored entry
  assign level = count_ff;
  reg [AW:0] stored_ff;
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      stored_ff <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if ((!out_valid || out_ready) && stored_ff != {(AW+1){1'b0}}) begin
        out_data <= mem[rd_ptr_ff];
        out_valid <= 1'b1;
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      stored_ff <= stored_ff + (push ? 1'b1 : 1'b0) -
        (((!out_valid || out_ready) && stored_ff != 0) ? 1'b1 : 1'b0);
      count_ff <= count_ff + (push ? 1'b1 : 1'b0) -
        ((out_valid && out_ready) ? 1'b1 : 1'b0);
    end
  end
endmodule // audio_fifo

// ---- rtl/legacy_audio_port_bank.v ----
// legacy audio i/o port bank: fm, mixer, reset/status, handshake, fifo port
`include "legacy_audio_regs.vh"

// Overview of operation
// - low fm data writes selected low register
// - high data acts as low in emulation
// - mixer index reads back, top bit zero
// - reset bit1 holds fifo, not compat mode
// - reset bit0 holds audio core
// - status read sets both activity markers
// - mixer port access clears mixer marker
// - fm accesses, reset/command writes, data reads and dma clear general marker
// - serial flag from mixer 48h and clock
// - bit2 shows pending midi command
// - power bit6 returns volume-up pin
// - power bit5 holds fm synth reset
// - command write sets busy until consumed
// - avail flags set on byte, cleared by read
// - extended mode fifo full/empty/half flags
// - processor, half-empty and overflow irq flags
// - buffer status read clears all irqs
// - fifo port moves bytes by pio
// - low index write selects, enters emulation
module legacy_audio_port_bank (
  input wire clk,
  input wire srst,
  input wire [3:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire dma_access,
  input wire native_mode_set,
  input wire compat_mode,
  input wire volume_up_pin,
  input wire serial_bit_clk,
  output reg fm_wr_stb,
  output reg fm_bank_high,
  output reg [7:0] fm_reg_addr,
  output reg [7:0] fm_reg_data,
  output reg emulation_mode,
  output reg soft_core_hold,
  output reg fifo_hold,
  output reg fm_synth_hold,
  output reg suspend_req,
  output reg [6:0] mixer_addr,
  output reg [7:0] mixer_wdata,
  output reg mixer_wr_stb,
  input wire [7:0] mixer_rdata,
  output reg cmd_valid,
  output reg [7:0] cmd_byte,
  input wire cmd_taken,
  input wire reply_valid,
  input wire [7:0] reply_byte,
  input wire midi_command_pending,
  input wire proc_irq_evt,
  input wire ovf_irq_evt,
  input wire extended_mode,
  output wire fifo_out_valid,
  input wire fifo_out_ready,
  output wire [7:0] fifo_out_data,
  input wire fifo_in_valid,
  output reg fifo_in_ready,
  input wire [7:0] fifo_in_data,
  output reg irq_pending
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg volume_up_pin_s1_ff;
  reg volume_up_pin_s2_ff;
  reg sclk_s1_ff;
  reg sclk_s2_ff;
  reg sclk_s3_ff;
  always @(posedge clk) begin
    volume_up_pin_s1_ff <= volume_up_pin;
    volume_up_pin_s2_ff <= volume_up_pin_s1_ff;
    sclk_s1_ff <= serial_bit_clk;
    sclk_s2_ff <= sclk_s1_ff;
    sclk_s3_ff <= sclk_s2_ff;
  end

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  wire wr_fm_lo_idx = io_wr && io_addr == `OFS_FM_LOW_INDEX;
  wire wr_fm_lo_dat = io_wr && io_addr == `OFS_FM_LOW_DATA;
  wire wr_fm_hi_idx = io_wr && io_addr == `OFS_FM_HIGH_INDEX;
  wire wr_fm_hi_dat = io_wr && io_addr == `OFS_FM_HIGH_DATA;
  wire wr_mix_idx = io_wr && io_addr == `OFS_MIXER_INDEX;
  wire wr_mix_val = io_wr && io_addr == `OFS_MIXER_VALUE;
  wire wr_reset = io_wr && io_addr == `OFS_RESET_FLAGS;
  wire wr_power = io_wr && io_addr == `OFS_POWER_CONTROL;
  wire wr_cmd = io_wr && io_addr == `OFS_HANDSHAKE;
  wire wr_pio = io_wr && io_addr == `OFS_FIFO_PIO;
  wire rd_status = io_rd && io_addr == `OFS_RESET_FLAGS;
  wire rd_data = io_rd && io_addr == `OFS_PROC_READ_DATA;
  wire rd_rbuf = io_rd && io_addr == `OFS_READ_BUF_STATE;
  wire rd_pio = io_rd && io_addr == `OFS_FIFO_PIO;
  wire rd_fm = io_rd && io_addr[3:2] == 2'b00;
  wire acc_mix = (io_rd || io_wr) &&
    (io_addr == `OFS_MIXER_INDEX || io_addr == `OFS_MIXER_VALUE);

  // ------------------------------------------------------------
  // fm synthesizer ports
  // ------------------------------------------------------------
  reg [7:0] fm_lo_idx_ff;
  reg [7:0] fm_hi_idx_ff;
  always @(posedge clk) begin
    if (srst) begin
      fm_lo_idx_ff <= 8'h00;
      fm_hi_idx_ff <= 8'h00;
      emulation_mode <= 1'b0;
      fm_wr_stb <= 1'b0;
      fm_bank_high <= 1'b0;
      fm_reg_addr <= 8'h00;
      fm_reg_data <= 8'h00;
    end else begin
      fm_wr_stb <= 1'b0;
      if (wr_fm_lo_idx) begin
        fm_lo_idx_ff <= io_wdata;
        emulation_mode <= 1'b1;
      end else if (native_mode_set) begin
        emulation_mode <= 1'b0;
      end
      if (wr_fm_hi_idx)
        fm_hi_idx_ff <= io_wdata;
      if (wr_fm_lo_dat || (wr_fm_hi_dat && emulation_mode)) begin
        fm_wr_stb <= 1'b1;
        fm_bank_high <= 1'b0;
        fm_reg_addr <= fm_lo_idx_ff;
        fm_reg_data <= io_wdata;
      end else if (wr_fm_hi_dat) begin
        fm_wr_stb <= 1'b1;
        fm_bank_high <= 1'b1;
        fm_reg_addr <= fm_hi_idx_ff;
        fm_reg_data <= io_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // mixer ports
  // ------------------------------------------------------------
  reg [7:0] ser_cfg_ff;
  always @(posedge clk) begin
    if (srst) begin
      mixer_addr <= 7'h00;
      mixer_wdata <= 8'h00;
      mixer_wr_stb <= 1'b0;
      ser_cfg_ff <= 8'h00;
    end else begin
      mixer_wr_stb <= 1'b0;
      if (wr_mix_idx)
        mixer_addr <= io_wdata[6:0];
      if (wr_mix_val) begin
        mixer_wr_stb <= 1'b1;
        mixer_wdata <= io_wdata;
        if (mixer_addr == `MIXER_SERIAL_REG)
          ser_cfg_ff <= io_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // reset and power control
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      soft_core_hold <= 1'b0;
      fifo_hold <= 1'b0;
      fm_synth_hold <= 1'b0;
      suspend_req <= 1'b0;
    end else begin
      if (wr_reset) begin
        soft_core_hold <= io_wdata[`BIT_SOFT_CORE_HOLD];
        fifo_hold <= io_wdata[`BIT_FIFO_HOLD] && !compat_mode;
      end
      if (wr_power) begin
        // the suspend request is held as written until the next power write; sequencing is software's
        suspend_req <= io_wdata[`BIT_SUSPEND_REQ];
        fm_synth_hold <= io_wdata[`BIT_FM_HOLD];
      end
    end
  end

  // ------------------------------------------------------------
  // activity markers and serial activity
  // ------------------------------------------------------------
  reg mix_act_ff;
  reg gen_act_ff;
  reg [7:0] sclk_timer_ff;
  wire sclk_edge = sclk_s2_ff ^ sclk_s3_ff;
  always @(posedge clk) begin
    if (srst) begin
      mix_act_ff <= 1'b0;
      gen_act_ff <= 1'b0;
      sclk_timer_ff <= 8'h00;
    end else begin
      // the status read itself is the setting event, so it wins
      if (rd_status)
        mix_act_ff <= 1'b1;
      else if (acc_mix)
        mix_act_ff <= 1'b0;
      if (rd_status)
        gen_act_ff <= 1'b1;
      else if ((io_wr && (io_addr[3:2] == 2'b00 || io_addr == `OFS_RESET_FLAGS
          || io_addr == `OFS_HANDSHAKE)) || rd_fm || rd_data || dma_access)
        gen_act_ff <= 1'b0;
      // clock counts as periodic while it toggled within the window
      if (sclk_edge)
        sclk_timer_ff <= `SCLK_WINDOW;
      else if (sclk_timer_ff != 8'h00)
        sclk_timer_ff <= sclk_timer_ff - 8'h01;
    end
  end
  wire serial_act = ser_cfg_ff[`SER_ENABLE_BIT] || ser_cfg_ff[`SER_RESET_BIT]
    || (ser_cfg_ff[`SER_ACTIVE_BIT] && sclk_timer_ff != 8'h00);

  // ------------------------------------------------------------
  // processor handshake
  // ------------------------------------------------------------
  reg avail_ff;
  reg [7:0] reply_ff;
  always @(posedge clk) begin
    if (srst) begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      avail_ff <= 1'b0;
      reply_ff <= 8'h00;
    end else begin
      // writes while busy are dropped; software must poll first
      if (wr_cmd && !cmd_valid) begin
        cmd_valid <= 1'b1;
        cmd_byte <= io_wdata;
      end else if (cmd_taken) begin
        cmd_valid <= 1'b0;
      end
      if (reply_valid) begin
        avail_ff <= 1'b1;
        reply_ff <= reply_byte;
      end else if (rd_data) begin
        avail_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // extended fifo and interrupt flags
  // ------------------------------------------------------------
  wire pio_out_valid;
  wire [7:0] pio_out_data;
  wire [`FIFO_AW:0] fifo_level;
  wire fifo_full = fifo_level == `FIFO_DEPTH;
  wire fifo_empty = fifo_level == 9'h000;
  wire fifo_half = fifo_level <= `FIFO_HALF_LEVEL;
  reg half_prev_ff;
  reg proc_irq_ff;
  reg half_irq_ff;
  reg ovf_irq_ff;
  wire fifo_srst = srst || fifo_hold;
  // one write port: a programmed write that meets a stream byte in the
  // same cycle is lost, so software uses one path at a time
  wire stream_push = fifo_in_valid && fifo_in_ready;
  wire pio_push = wr_pio && extended_mode;
  wire fifo_push = pio_push || stream_push;
  audio_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .clk(clk),
    .srst(fifo_srst),
    .in_valid(fifo_push),
    .in_ready(),
    .in_data(stream_push ? fifo_in_data : io_wdata),
    .out_valid(pio_out_valid),
    .out_ready(fifo_out_ready || (rd_pio && extended_mode)),
    .out_data(pio_out_data),
    .level(fifo_level)
  );
  // the fifo's own output register drives the stream side, so valid and
  // ready stay paired on the same cycle
  assign fifo_out_valid = pio_out_valid;
  assign fifo_out_data = pio_out_data;
  always @(posedge clk) begin
    if (srst) begin
      half_prev_ff <= 1'b1;
      proc_irq_ff <= 1'b0;
      half_irq_ff <= 1'b0;
      ovf_irq_ff <= 1'b0;
      fifo_in_ready <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      half_prev_ff <= fifo_half;
      // new events win over the clearing read
      proc_irq_ff <= proc_irq_evt || (proc_irq_ff && !rd_rbuf);
      half_irq_ff <= (fifo_half != half_prev_ff) ||
        (half_irq_ff && !rd_rbuf);
      ovf_irq_ff <= (ovf_irq_evt && extended_mode) ||
        (ovf_irq_ff && !rd_rbuf);
      irq_pending <= proc_irq_ff || half_irq_ff || ovf_irq_ff;
      // one slot to spare: a push on the next cycle still fits
      fifo_in_ready <= fifo_level < `FIFO_DEPTH - 1;
    end
  end

  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    case (io_addr)
      `OFS_MIXER_INDEX: nxt_rdata = {1'b0, mixer_addr};
      `OFS_MIXER_VALUE: nxt_rdata = mixer_rdata;
      `OFS_RESET_FLAGS: begin
        nxt_rdata[`BIT_MIX_ACT] = mix_act_ff;
        nxt_rdata[`BIT_GEN_ACT] = gen_act_ff;
        nxt_rdata[`BIT_SERIAL_ACT] = serial_act;
        nxt_rdata[`BIT_MIDI_PENDING] = midi_command_pending;
        nxt_rdata[`BIT_FIFO_HOLD] = fifo_hold;
        nxt_rdata[`BIT_SOFT_CORE_HOLD] = soft_core_hold;
      end
      `OFS_POWER_CONTROL: begin
        nxt_rdata[`BIT_SUSPEND_REQ] = suspend_req;
        nxt_rdata[`BIT_GENERAL_INPUT] = volume_up_pin_s2_ff;
        nxt_rdata[`BIT_FM_HOLD] = fm_synth_hold;
      end
      `OFS_PROC_READ_DATA: nxt_rdata = reply_ff;
      `OFS_HANDSHAKE: begin
        nxt_rdata[`BIT_BUSY] = cmd_valid;
        nxt_rdata[`BIT_AVAIL] = avail_ff;
        nxt_rdata[`BIT_FIFO_FULL] = extended_mode && fifo_full;
        nxt_rdata[`BIT_FIFO_EMPTY] = extended_mode && fifo_empty;
        nxt_rdata[`BIT_FIFO_HALF] = extended_mode && fifo_half;
        nxt_rdata[`BIT_PROC_IRQ] = proc_irq_ff;
        nxt_rdata[`BIT_HALF_IRQ] = half_irq_ff;
        nxt_rdata[`BIT_OVF_IRQ] = ovf_irq_ff;
      end
      `OFS_READ_BUF_STATE: nxt_rdata[`BIT_READ_SIDE_AVAIL_FLAG] = avail_ff;
      `OFS_FIFO_PIO: nxt_rdata = pio_out_valid ? pio_out_data : 8'h00;
      default: nxt_rdata = 8'h00;
    endcase
  end
  always @(posedge clk) begin
    if (srst)
      io_rdata <= `RESET_BYTE;
    else if (io_rd)
      io_rdata <= nxt_rdata;
  end
endmodule // legacy_audio_port_bank

// ---- test/legacy_audio_bank_sva.sv ----
// assertion checker bound to the legacy audio port bank
module legacy_audio_bank_sva (
  input wire clk,
  input wire srst,
  input wire [3:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire fm_wr_stb,
  input wire fm_bank_high,
  input wire [7:0] fm_reg_data,
  input wire emulation_mode,
  input wire soft_core_hold,
  input wire fifo_hold,
  input wire fm_synth_hold,
  input wire [6:0] mixer_addr,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire cmd_taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire [6:0] wlow = io_wdata[6:0];
  // ---------------------------------------------------------------
  // handshake and read steps
  // ---------------------------------------------------------------
  sequence s_cmd_wr;
    io_wr && io_addr == 4'hc;
  endsequence
  sequence s_rd(logic [3:0] a);
    io_rd && io_addr == a;
  endsequence
  chk_busy_set: assert property ((s_cmd_wr ##0 !cmd_valid) |=>
    cmd_valid && cmd_byte == $past(io_wdata)) else $error("busy not set");
  chk_busy_hold: assert property (cmd_valid && !cmd_taken |=> cmd_valid)
    else $error("busy dropped early");
  chk_busy_drop: assert property ((s_cmd_wr ##0 cmd_valid && !cmd_taken)
    |=> cmd_byte == $past(cmd_byte)) else $error("busy write taken");
  chk_fm_low: assert property (io_wr && io_addr == 4'h1 |=> fm_wr_stb &&
    !fm_bank_high && fm_reg_data == $past(io_wdata)) else $error("fm low");
  chk_fm_mirror: assert property (io_wr && io_addr == 4'h3 &&
    emulation_mode |=> fm_wr_stb && !fm_bank_high) else $error("fm mirror");
  chk_emul_entry: assert property (io_wr && io_addr == 4'h0
    |=> emulation_mode) else $error("no emulation");
  chk_mix_addr: assert property (io_wr && io_addr == 4'h4
    |=> mixer_addr == $past(wlow)) else $error("mixer index");
  chk_mix_read: assert property (s_rd(4'h4) |=>
    io_rdata == {1'b0, $past(mixer_addr)}) else $error("index read");
  chk_core_hold: assert property (io_wr && io_addr == 4'h6 |=>
    soft_core_hold == $past(io_wdata[0])) else $error("core hold");
  chk_fm_hold: assert property (io_wr && io_addr == 4'h7 |=>
    fm_synth_hold == $past(io_wdata[5])) else $error("fm hold");
  chk_status_bits: assert property (s_rd(4'h6) |=> !io_rdata[7] &&
    io_rdata[1:0] == {$past(fifo_hold), $past(soft_core_hold)})
    else $error("status bits");
endmodule // legacy_audio_bank_sva

bind legacy_audio_port_bank legacy_audio_bank_sva sva_u (.clk, .srst,
  .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .fm_wr_stb,
  .fm_bank_high, .fm_reg_data, .emulation_mode, .soft_core_hold,
  .fifo_hold, .fm_synth_hold, .mixer_addr, .cmd_valid, .cmd_byte,
  .cmd_taken);

// ---- test/audio_proc_model.sv ----
// embedded audio processor model: consumes command bytes and replies
module audio_proc_model (
  input wire clk,
  input wire srst,
  input wire slow,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  output reg cmd_taken,
  output reg reply_valid,
  output reg [7:0] reply_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [4:0] wait_ff;
  reg done_ff;
  always @(posedge clk) begin
    cmd_taken <= 1'b0;
    reply_valid <= 1'b0;
    // outside the answer pulse the reply lines swap between the last byte and its complement each cycle
    reply_byte <= ~reply_byte;
    if (srst) begin
      wait_ff <= 5'd0;
      done_ff <= 1'b0;
      reply_byte <= 8'h00;
    end else if (!cmd_valid) begin
      wait_ff <= 5'd0;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      wait_ff <= wait_ff + 5'd1;
      if (wait_ff == (slow ? 5'd20 : 5'd2)) begin
        cmd_taken <= 1'b1;
        reply_valid <= 1'b1;
        reply_byte <= cmd_byte + 8'h01;
        done_ff <= 1'b1;
      end
    end
  end
endmodule // audio_proc_model

// ---- test/testbench.sv ----
// self-checking bench for the legacy audio port bank
`define check(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk, srst = 1, io_rd = 0, io_wr = 0, dma_access = 0, slow = 0;
  reg native_mode_set = 0, compat_mode = 0, volume_up_pin = 0;
  reg serial_bit_clk = 0, midi_command_pending = 0, proc_irq_evt = 0;
  reg ovf_irq_evt = 0, extended_mode = 0, fifo_out_ready = 0;
  reg fifo_in_valid = 0;
  reg [3:0] io_addr = 0;
  reg [7:0] io_wdata = 0, mixer_rdata = 8'h5a, fifo_in_data = 0, d, last_b;
  reg [9:0] got_n = 0;
  integer error_cnt = 0, check_count = 0, i, n, cyc = 0;
  wire [7:0] io_rdata, fm_reg_addr, fm_reg_data, mixer_wdata, cmd_byte;
  wire [7:0] reply_byte, fifo_out_data;
  wire [6:0] mixer_addr;
  wire fm_wr_stb, fm_bank_high, emulation_mode, soft_core_hold, fifo_hold;
  wire fm_synth_hold, suspend_req, mixer_wr_stb, cmd_valid, cmd_taken;
  wire reply_valid, fifo_out_valid, fifo_in_ready, irq_pending;
  reg [4:0] op [0:5] = '{5'h10, 5'h04, 5'h15, 5'h0a, 5'h16, 5'h1c};
  reg [1:0] mk [0:5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b10};
  legacy_audio_port_bank dut_u (.clk, .srst, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .dma_access, .native_mode_set, .compat_mode,
    .volume_up_pin, .serial_bit_clk, .fm_wr_stb, .fm_bank_high,
    .fm_reg_addr, .fm_reg_data, .emulation_mode, .soft_core_hold,
    .fifo_hold, .fm_synth_hold, .suspend_req, .mixer_addr, .mixer_wdata,
    .mixer_wr_stb, .mixer_rdata, .cmd_valid, .cmd_byte, .cmd_taken,
    .reply_valid, .reply_byte, .midi_command_pending, .proc_irq_evt,
    .ovf_irq_evt, .extended_mode, .fifo_out_valid, .fifo_out_ready,
    .fifo_out_data, .fifo_in_valid, .fifo_in_ready, .fifo_in_data,
    .irq_pending);
  audio_proc_model model_u (.clk, .srst, .slow, .cmd_valid, .cmd_byte,
    .cmd_taken, .reply_valid, .reply_byte);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (fifo_out_valid && fifo_out_ready) begin
      got_n <= got_n + 10'd1;
      last_b <= fifo_out_data;
    end
    // the whole sequence needs well under two thousand cycles
    if (cyc == 5000) begin
      error_cnt++;
      summarize;
    end
  end
  // ---------------------------------------------------------------
  // host port cycles
  // ---------------------------------------------------------------
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      io_addr <= a;
      io_wdata <= v;
      io_wr <= 1;
      @(posedge clk);
      io_wr <= 0;
      @(posedge clk);
      #1;
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    begin
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1;
      @(posedge clk);
      io_rd <= 0;
      @(posedge clk);
      #1 v = io_rdata;
    end
  endtask
  task pulse(input [1:0] k);
    begin
      @(posedge clk);
      {ovf_irq_evt, proc_irq_evt, dma_access, native_mode_set} <= 4'd1 << k;
      @(posedge clk);
      {ovf_irq_evt, proc_irq_evt, dma_access, native_mode_set} <= 4'd0;
      @(posedge clk);
    end
  endtask
  task poll;
    begin
      rd(4'hc, d);
      for (n = 0; d[7] && n < 60; n++) rd(4'hc, d);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    wr(4'h0, 8'h20);
    `check("emulation", 1'b1, emulation_mode)
    wr(4'h1, 8'ha5);
    `check("fm addr", 8'h20, fm_reg_addr)
    `check("fm data", 8'ha5, fm_reg_data)
    wr(4'h3, 8'h3c);
    `check("mirror bank", 1'b0, fm_bank_high)
    pulse(0);
    wr(4'h2, 8'h11);
    wr(4'h3, 8'h44);
    `check("high bank", 1'b1, fm_bank_high)
    `check("high addr", 8'h11, fm_reg_addr)
    wr(4'h4, 8'hc8);
    rd(4'h4, d);
    `check("mix index", 8'h48, d)
    rd(4'h5, d);
    `check("mix data", 8'h5a, d)
    wr(4'h5, 8'h80);
    `check("mix wdata", 8'h80, mixer_wdata)
    rd(4'h6, d);
    `check("serial act", 1'b1, d[4])
    wr(4'h5, 8'h10);
    rd(4'h6, d);
    `check("serial idle", 1'b0, d[4])
    for (i = 0; i < 8; i++) @(posedge clk) serial_bit_clk <= ~serial_bit_clk;
    rd(4'h6, d);
    `check("serial clocked", 1'b1, d[4])
    rd(4'h6, d);
    rd(4'h6, d);
    `check("markers set", 2'b11, d[6:5])
    for (i = 0; i < 6; i++) begin
      rd(4'h6, d);
      if (op[i][4]) wr(op[i][3:0], 8'h00);
      else rd(op[i][3:0], d);
      rd(4'h6, d);
      `check("markers", mk[i], d[6:5])
    end
    rd(4'h6, d);
    pulse(1);
    rd(4'h6, d);
    `check("dma marker", 2'b10, d[6:5])
    wr(4'h6, 8'h01);
    `check("core hold", 1'b1, soft_core_hold)
    wr(4'h6, 8'h02);
    `check("core free", 1'b0, soft_core_hold)
    `check("fifo hold", 1'b1, fifo_hold)
    @(posedge clk) compat_mode <= 1;
    wr(4'h6, 8'h02);
    `check("compat hold", 1'b0, fifo_hold)
    @(posedge clk) compat_mode <= 0;
    wr(4'h6, 8'h00);
    for (i = 1; i >= 0; i--) begin
      @(posedge clk) volume_up_pin <= i[0];
      repeat (3) @(posedge clk);
      rd(4'h7, d);
      `check("gpi", i[0], d[6])
    end
    wr(4'h7, 8'ha0);
    `check("fm hold", 1'b1, fm_synth_hold)
    `check("suspend", 1'b1, suspend_req)
    wr(4'h7, 8'h00);
    `check("fm free", 1'b0, fm_synth_hold)
    @(posedge clk) midi_command_pending <= 1;
    rd(4'h6, d);
    `check("midi busy", 1'b1, d[2])
    @(posedge clk) midi_command_pending <= 0;
    poll;
    rd(4'ha, d);
    @(posedge clk) slow <= 1;
    wr(4'hc, 8'h5e);
    rd(4'hc, d);
    `check("busy", 1'b1, d[7])
    wr(4'hc, 8'h22);
    `check("refused", 8'h5e, cmd_byte)
    poll;
    `check("busy clear", 2'b01, d[7:6])
    rd(4'he, d);
    `check("rd avail", 1'b1, d[7])
    rd(4'ha, d);
    `check("reply", 8'h5f, d)
    rd(4'hc, d);
    `check("avail off", 1'b0, d[6])
    @(posedge clk) extended_mode <= 1;
    for (i = 0; i < 257; i++) wr(4'hf, (i < 256) ? i[7:0] : 8'hee);
    rd(4'hc, d);
    `check("fifo full", 3'b100, d[5:3])
    `check("half irq", 1'b1, d[1])
    `check("in ready full", 1'b0, fifo_in_ready)
    @(posedge clk) fifo_out_ready <= 1;
    for (n = 0; got_n < 256 && n < 1000; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    `check("drained", 10'd256, got_n)
    `check("last byte", 8'hff, last_b)
    rd(4'hc, d);
    `check("fifo empty", 3'b011, d[5:3])
    `check("in ready", 1'b1, fifo_in_ready)
    @(posedge clk) fifo_in_data <= 8'h6b;
    fifo_in_valid <= 1;
    @(posedge clk) fifo_in_valid <= 0;
    repeat (3) @(posedge clk);
    `check("stream byte", 8'h6b, last_b)
    rd(4'he, d);
    pulse(2);
    pulse(3);
    rd(4'hc, d);
    `check("irq flags", 2'b11, {d[2], d[0]})
    `check("irq line", 1'b1, irq_pending)
    rd(4'he, d);
    rd(4'hc, d);
    `check("irq cleared", 3'b000, d[2:0])
    `check("irq line off", 1'b0, irq_pending)
    summarize;
  end
endmodule // testbench
